// >>> gp_map.svh
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

// register indices, byte address is four times the index
`define GP_IDX_PORT_A 8'h05
`define GP_IDX_PORT_B 8'h06
`define GP_IDX_INTC 8'h0b
`define GP_IDX_RMW_MASK 8'h0c
`define GP_IDX_CMP 8'h1f
`define GP_IDX_OPT 8'h81
`define GP_IDX_PA_DIR 8'h85
`define GP_IDX_PB_DIR 8'h86
`define GP_IDX_VREF 8'h9f

// reset values
`define GP_RST_OPT 8'hff
`define GP_RST_PA_DIR 5'h1f
`define GP_RST_PB_DIR 8'hff
`define GP_RST_CMP 4'h0
`define GP_RST_VREF 8'h00
`define GP_RST_RMW_MASK 8'hff

// field positions
`define GP_BIT_PULLUP_N 7
`define GP_BIT_GIE 7
`define GP_BIT_CHG_EN 3
`define GP_BIT_CHG_FLAG 0
`define GP_BIT_VREN 7
`define GP_BIT_VROE 6
`define GP_BIT_VREF_GAP 4

// comparator modes with their own port a decode, off leaves port a digital except pin 2 while the vref output is enabled
`define GP_CM_OFF 3'h7
`define GP_CM_OUTPUTS 3'h6

`endif

// >>> gp_pkg.sv
package gp_pkg;

    typedef struct packed {
        logic [4:0] pa_s1;
        logic [4:0] pa_s2;
        logic [7:0] pb_s1;
        logic [7:0] pb_s2;
        logic [4:0] pa_lat;
        logic [7:0] pb_lat;
        logic [4:0] pa_dir;
        logic [7:0] pb_dir;
        logic [7:0] opt;
        logic [3:0] cmp;
        logic [7:0] vref;
        logic [7:0] rmw_mask;
        logic global_interrupt_enable;
        logic chg_en;
        logic chg_flag;
        logic [3:0] old;
        logic [7:0] rdata;
        logic err;
    } gp_state_t;

endpackage

// >>> gp_gpio.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "gp_map.svh"
module gp_gpio
    import gp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] pa_in,
    output logic [4:0] pa_out,
    output logic [4:0] pa_oe_n,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_n,
    output logic [7:0] pb_pullup,
    input wire logic cmp1_result,
    input wire logic cmp2_result,
    output logic [2:0] comparator_mode,
    output logic comparator_input_sel,
    output logic [7:0] voltage_ref_setting,
    output logic vref_out_en,
    output logic timer_ext_clock_in,
    output logic external_interrupt_pin,
    output logic prog_clock_in,
    output logic prog_data_in,
    output logic change_irq,
    output logic wake_request
);

    gp_state_t s;
    gp_state_t next_s;

    logic [7:0] idx;
    logic hit_hi;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic sel_pa;
    logic sel_pb;
    logic sel_intc;
    logic sel_rmw;
    logic sel_cmp;
    logic sel_opt;
    logic sel_pa_dir;
    logic sel_pb_dir;
    logic sel_vref;
    logic mapped;
    logic [3:0] pa_analog;
    logic [4:0] pa_read;
    logic [7:0] read_mux;
    logic [3:0] mismatch_bits;
    logic mismatch;
    logic pb_access;
    logic chg_set;
    logic chg_clear;
    logic [2:0] cm;
    logic [4:0] pa_val;

    // apb decode
    assign idx = paddr[9:2];
    assign hit_hi = (paddr[11:10] == 2'h0);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && !s.err;
    assign rd = access && !pwrite && !s.err;
    assign sel_pa = hit_hi && (idx == `GP_IDX_PORT_A);
    assign sel_pb = hit_hi && (idx == `GP_IDX_PORT_B);
    assign sel_intc = hit_hi && (idx == `GP_IDX_INTC);
    assign sel_rmw = hit_hi && (idx == `GP_IDX_RMW_MASK);
    assign sel_cmp = hit_hi && (idx == `GP_IDX_CMP);
    assign sel_opt = hit_hi && (idx == `GP_IDX_OPT);
    assign sel_pa_dir = hit_hi && (idx == `GP_IDX_PA_DIR);
    assign sel_pb_dir = hit_hi && (idx == `GP_IDX_PB_DIR);
    assign sel_vref = hit_hi && (idx == `GP_IDX_VREF);
    assign mapped = sel_pa || sel_pb || sel_intc || sel_rmw || sel_cmp || sel_opt
        || sel_pa_dir || sel_pb_dir || sel_vref;

    // port a pin modes
    assign cm = s.cmp[2:0];
    assign vref_out_en = s.vref[`GP_BIT_VREN] && s.vref[`GP_BIT_VROE];
    always_comb
    begin
        unique case (cm)
            `GP_CM_OFF: pa_analog = 4'h0;
            `GP_CM_OUTPUTS: pa_analog = 4'h7;
            default: pa_analog = 4'hf;
        endcase
        if (vref_out_en)
        begin
            pa_analog[2] = 1'b1;
        end
    end

    // analog pins read zero, upper bits zero
    assign pa_read = s.pa_s2 & ~{1'b0, pa_analog};

    // change detection on upper inputs
    assign mismatch_bits = (s.pb_s2[7:4] ^ s.old) & s.pb_dir[7:4];
    assign mismatch = |mismatch_bits;
    assign pb_access = access && sel_pb && !s.err;
    assign chg_set = mismatch && !pb_access;
    assign chg_clear = wr && sel_intc && !pwdata[`GP_BIT_CHG_FLAG];

    always_comb
    begin
        read_mux = 8'h00;
        unique case (1'b1)
            sel_pa: read_mux = {3'h0, pa_read};
            sel_pb: read_mux = s.pb_s2;
            sel_intc: read_mux = {s.global_interrupt_enable, 3'h0, s.chg_en, 2'h0, s.chg_flag};
            sel_rmw: read_mux = s.rmw_mask;
            sel_cmp: read_mux = {cmp2_result, cmp1_result, 2'h0, s.cmp};
            sel_opt: read_mux = s.opt;
            sel_pa_dir: read_mux = {3'h0, s.pa_dir};
            sel_pb_dir: read_mux = s.pb_dir;
            sel_vref: read_mux = s.vref & ~(8'h01 << `GP_BIT_VREF_GAP);
            default: read_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        next_s = s;
        // two-stage pin synchronisers
        next_s.pa_s1 = pa_in;
        next_s.pa_s2 = s.pa_s1;
        next_s.pb_s1 = pb_in;
        next_s.pb_s2 = s.pb_s1;
        if (setup)
        begin
            next_s.err = !mapped;
            next_s.rdata = mapped ? read_mux : 8'h00;
        end
        if (wr)
        begin
            if (sel_pa)
            begin
                next_s.pa_lat = (pa_read & ~s.rmw_mask[4:0]) | (pwdata[4:0] & s.rmw_mask[4:0]);
            end
            if (sel_pb)
            begin
                next_s.pb_lat = (s.pb_s2 & ~s.rmw_mask) | (pwdata[7:0] & s.rmw_mask);
            end
            if (sel_intc)
            begin
                next_s.global_interrupt_enable = pwdata[`GP_BIT_GIE];
                next_s.chg_en = pwdata[`GP_BIT_CHG_EN];
            end
            if (sel_rmw)
            begin
                next_s.rmw_mask = pwdata[7:0];
            end
            if (sel_cmp)
            begin
                next_s.cmp = pwdata[3:0];
            end
            if (sel_opt)
            begin
                next_s.opt = pwdata[7:0];
            end
            if (sel_pa_dir)
            begin
                next_s.pa_dir = pwdata[4:0];
            end
            if (sel_pb_dir)
            begin
                next_s.pb_dir = pwdata[7:0];
            end
            if (sel_vref)
            begin
                next_s.vref = pwdata[7:0];
            end
        end
        if (pb_access)
        begin
            next_s.old = s.pb_s2[7:4];
        end
        // set wins over a clearing write
        next_s.chg_flag = chg_set || (s.chg_flag && !chg_clear);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s.pa_s1 <= 5'h00;
            s.pa_s2 <= 5'h00;
            s.pb_s1 <= 8'h00;
            s.pb_s2 <= 8'h00;
            s.pa_lat <= 5'h00;
            s.pb_lat <= 8'h00;
            s.pa_dir <= `GP_RST_PA_DIR;
            s.pb_dir <= `GP_RST_PB_DIR;
            s.opt <= `GP_RST_OPT;
            s.cmp <= `GP_RST_CMP;
            s.vref <= `GP_RST_VREF;
            s.rmw_mask <= `GP_RST_RMW_MASK;
            s.global_interrupt_enable <= 1'b0;
            s.chg_en <= 1'b0;
            s.chg_flag <= 1'b0;
            s.old <= 4'h0;
            s.rdata <= 8'h00;
            s.err <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // bus answers
    assign pready = 1'b1;
    assign pslverr = access && s.err;
    assign prdata = {24'h000000, s.rdata};

    // port a drivers
    always_comb
    begin
        pa_val = s.pa_lat;
        if (cm == `GP_CM_OUTPUTS)
        begin
            pa_val[3] = cmp1_result;
            pa_val[4] = cmp2_result;
        end
    end
    assign pa_out = {1'b0, pa_val[3:0]};
    assign pa_oe_n = {s.pa_dir[4] | pa_val[4], s.pa_dir[3:0]};

    // port b drivers
    assign pb_out = s.pb_lat;
    assign pb_oe_n = s.pb_dir;
    assign pb_pullup = {8{!s.opt[`GP_BIT_PULLUP_N]}} & s.pb_dir;

    // alternate functions
    assign comparator_mode = cm;
    assign comparator_input_sel = s.cmp[3];
    assign voltage_ref_setting = s.vref;
    assign timer_ext_clock_in = s.pa_s2[4];
    assign external_interrupt_pin = s.pb_s2[0];
    assign prog_clock_in = s.pb_s2[6];
    assign prog_data_in = s.pb_s2[7];

    // interrupt and wake
    assign change_irq = s.global_interrupt_enable && s.chg_en && s.chg_flag;
    assign wake_request = s.chg_en && s.chg_flag;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_write(logic sel);
        psel && penable && pwrite && sel && !s.err;
    endsequence

    sequence s_read(logic sel);
        psel && penable && !pwrite && sel && !s.err;
    endsequence

    property p_pb_dir_drive;
        s_write(sel_pb_dir) |=> (pb_oe_n == $past(pwdata[7:0]));
    endproperty
    a_pb_dir_drive: assert property (p_pb_dir_drive) else $error("port b direction not applied");

    property p_pb_read;
        psel && !penable && sel_pb ##1 s_read(sel_pb) |-> prdata[7:0] == $past(s.pb_s2);
    endproperty
    a_pb_read: assert property (p_pb_read) else $error("port b read not pin level");

    property p_pb_rmw;
        s_write(sel_pb) |=> pb_out == (($past(s.pb_s2) & ~$past(s.rmw_mask))
            | ($past(pwdata[7:0]) & $past(s.rmw_mask)));
    endproperty
    a_pb_rmw: assert property (p_pb_rmw) else $error("port b latch not read-modify-write");

    property p_pa_rmw;
        s_write(sel_pa) |=> s.pa_lat == (($past(pa_read) & ~$past(s.rmw_mask[4:0]))
            | ($past(pwdata[4:0]) & $past(s.rmw_mask[4:0])));
    endproperty
    a_pa_rmw: assert property (p_pa_rmw) else $error("port a latch not read-modify-write");

    property p_pullup_on;
        s_write(sel_opt) |=> pb_pullup == ({8{!$past(pwdata[7])}} & pb_oe_n);
    endproperty
    a_pullup_on: assert property (p_pullup_on) else $error("pull-up enable wrong");

    property p_pullup_out;
        (pb_pullup & ~pb_oe_n) == 8'h00;
    endproperty
    a_pullup_out: assert property (p_pullup_out) else $error("pull-up on output pin");

    property p_pullup_reset;
        $rose(presetn) |-> pb_pullup == 8'h00;
    endproperty
    a_pullup_reset: assert property (p_pullup_reset) else $error("pull-ups on after reset");

    property p_chg_set;
        (mismatch && !pb_access) |=> s.chg_flag;
    endproperty
    a_chg_set: assert property (p_chg_set) else $error("mismatch did not set flag");

    property p_chg_outputs;
        (((s.pb_s2[7:4] ^ s.old) & s.pb_dir[7:4]) == 4'h0) && !s.chg_flag |=> !s.chg_flag;
    endproperty
    a_chg_outputs: assert property (p_chg_outputs) else $error("flag set without input mismatch");

    property p_refresh;
        psel && penable && sel_pb && !s.err |=> s.old == $past(s.pb_s2[7:4]);
    endproperty
    a_refresh: assert property (p_refresh) else $error("compare value not refreshed");

    property p_set_wins;
        mismatch && !pb_access && chg_clear |=> s.chg_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a pending mismatch");

    property p_hold;
        s.chg_flag && mismatch && !pb_access |=> s.chg_flag [*1] ##1 1'b1;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped while mismatch persists");

    property p_wake;
        s.chg_flag && s.chg_en |-> wake_request;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on pending change");

    property p_indep;
        mismatch && !pb_access && !s.global_interrupt_enable && !s.chg_en |=> s.chg_flag;
    endproperty
    a_indep: assert property (p_indep) else $error("flag gated by enables");

    property p_pa_upper;
        s_read(sel_pa) |-> prdata[7:5] == 3'h0;
    endproperty
    a_pa_upper: assert property (p_pa_upper) else $error("port a upper bits not zero");

    property p_open_drain;
        !pa_oe_n[4] |-> !pa_out[4] && !pa_val[4];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");

    property p_analog_zero;
        (cm != `GP_CM_OFF) && (cm != `GP_CM_OUTPUTS) ##1 (psel && penable && !pwrite && sel_pa && !s.err
            && $stable(s.cmp)) |-> prdata[3:0] == 4'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("comparator input read nonzero");

    property p_sync;
        $stable(pb_in) [*3] |-> s.pb_s2 == $past(pb_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin synchroniser depth wrong");

    property p_pa_dir;
        s_write(sel_pa_dir) |=> pa_oe_n[3:0] == $past(pwdata[3:0]);
    endproperty
    a_pa_dir: assert property (p_pa_dir) else $error("port a direction not applied");

endmodule

// >>> gp_pins.sv
`timescale 1ns/10ps
module gp_pins (
    input wire logic pclk,
    input wire logic [4:0] pa_out,
    input wire logic [4:0] pa_oe_n,
    input wire logic [4:0] ext_pa,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pb_pullup,
    input wire logic [7:0] ext_pb,
    input wire logic [7:0] ext_pb_en,
    output logic [4:0] pa_in,
    output logic [7:0] pb_in
);
    logic [7:0] last = 8'h00;
    always_ff @(posedge pclk)
    begin
        last <= pb_in;
    end
    // released pins follow the board, undriven lines wander
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            pa_in[i] = pa_oe_n[i] ? ext_pa[i] : pa_out[i];
        end
        for (int i = 0; i < 8; i++)
        begin
            pb_in[i] = !pb_oe_n[i] ? pb_out[i] : ext_pb_en[i] ? ext_pb[i] : pb_pullup[i] ? 1'b1 : ~last[i];
        end
    end
endmodule

// >>> dual_port_gpio_with_change_irq_tb_top.sv
`timescale 1ns/10ps
`include "gp_map.svh"
module dual_port_gpio_with_change_irq_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, vref_out_en, timer_ext_clock_in, external_interrupt_pin;
    logic prog_clock_in, prog_data_in, change_irq, wake_request;
    logic [4:0] pa_in, pa_out, pa_oe_n;
    logic [4:0] ext_pa = 5'h1f;
    logic [7:0] pb_in, pb_out, pb_oe_n, pb_pullup;
    logic [7:0] ext_pb = 8'h00;
    logic [7:0] ext_pb_en = 8'hff;
    logic [2:0] comparator_mode;
    logic cmp1 = 1'b1;
    logic cmp2 = 1'b0;
    logic comparator_input_sel;
    logic [7:0] voltage_ref_setting;
    logic [31:0] seed = 32'h25bd;
    logic [31:0] rdv;
    logic err;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int m_dir, m_lat, m_ext, w, m;

    always #5 pclk = ~pclk;

    gp_gpio dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup), .cmp1_result(cmp1), .cmp2_result(cmp2),
        .comparator_mode(comparator_mode), .comparator_input_sel(comparator_input_sel),
        .voltage_ref_setting(voltage_ref_setting),
        .vref_out_en(vref_out_en), .timer_ext_clock_in(timer_ext_clock_in),
        .external_interrupt_pin(external_interrupt_pin), .prog_clock_in(prog_clock_in),
        .prog_data_in(prog_data_in), .change_irq(change_irq), .wake_request(wake_request));

    gp_pins pins (.pclk(pclk), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .ext_pa(ext_pa), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup), .ext_pb(ext_pb), .ext_pb_en(ext_pb_en),
        .pa_in(pa_in), .pb_in(pb_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // port b pin levels as the model sees them
    function automatic int pbw();
        return ((~m_dir & m_lat) | (m_dir & m_ext)) & 255;
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] idx, input int exp);
        apb(1'b0, idx, 32'h0);
        chk(rdv, exp);
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pb_pullup, 0);
        chk(pb_oe_n, 8'hff);
        rdchk(`GP_IDX_OPT, 8'hff);
        rdchk(`GP_IDX_PA_DIR, 8'h1f);
        rdchk(`GP_IDX_PB_DIR, 8'hff);
        rdchk(8'h40, 0);
        chk(err, 1'b1);
        rdchk(`GP_IDX_PORT_A, 8'h10);
        rdchk(`GP_IDX_CMP, 8'h40);
        apb(1'b1, `GP_IDX_CMP, 8'h07);
        chk(comparator_mode, 3'h7);
        rdchk(`GP_IDX_PORT_A, 8'h1f);
        apb(1'b1, `GP_IDX_VREF, 8'hd5);
        chk(vref_out_en, 1'b1);
        chk(voltage_ref_setting, 8'hd5);
        rdchk(`GP_IDX_VREF, 8'hc5);
        rdchk(`GP_IDX_PORT_A, 8'h1b);
        apb(1'b1, `GP_IDX_VREF, 8'h00);
        apb(1'b1, `GP_IDX_PA_DIR, 8'h00);
        apb(1'b1, `GP_IDX_PORT_A, 8'h1f);
        chk(pa_out, 5'h0f);
        chk(pa_oe_n, 5'h10);
        repeat (3) @(posedge pclk);
        rdchk(`GP_IDX_PORT_A, 8'h1f);
        chk(timer_ext_clock_in, 1'b1);
        apb(1'b1, `GP_IDX_PORT_A, 8'h00);
        chk(pa_oe_n, 5'h00);
        repeat (3) @(posedge pclk);
        rdchk(`GP_IDX_PORT_A, 8'h00);
        chk(timer_ext_clock_in, 1'b0);
        cmp2 <= 1'b1;
        apb(1'b1, `GP_IDX_CMP, 8'h0e);
        chk(comparator_input_sel, 1'b1);
        chk(pa_out, 5'h08);
        chk(pa_oe_n, 5'h10);
        repeat (3) @(posedge pclk);
        rdchk(`GP_IDX_PORT_A, 8'h18);
        rdchk(`GP_IDX_CMP, 8'hce);
        cmp2 <= 1'b0;
        @(posedge pclk);
        chk(pa_oe_n, 5'h00);
        apb(1'b1, `GP_IDX_CMP, 8'h07);
        for (int i = 0; i < 4; i++)
        begin
            m_dir = rnd() & 255;
            m_ext = rnd() & 255;
            w = rnd() & 255;
            ext_pb <= m_ext[7:0];
            ext_pb_en <= m_dir[7:0];
            apb(1'b1, `GP_IDX_PB_DIR, m_dir);
            apb(1'b1, `GP_IDX_PORT_B, w);
            m_lat = w;
            chk(pb_out, m_lat);
            chk(pb_oe_n, m_dir);
            repeat (3) @(posedge pclk);
            rdchk(`GP_IDX_PORT_B, pbw());
            chk(external_interrupt_pin, pbw() & 1);
            chk({prog_data_in, prog_clock_in}, pbw() >> 6);
            m = 1 << (rnd() & 7);
            w = rnd() & 255;
            apb(1'b1, `GP_IDX_RMW_MASK, m);
            apb(1'b1, `GP_IDX_PORT_B, w);
            m_lat = (pbw() & ~m & 255) | (w & m);
            chk(pb_out, m_lat);
            apb(1'b1, `GP_IDX_RMW_MASK, 8'hff);
            repeat (3) @(posedge pclk);
        end
        apb(1'b1, `GP_IDX_OPT, 8'h7f);
        chk(pb_pullup, m_dir & 255);
        ext_pb_en <= 8'h00;
        repeat (3) @(posedge pclk);
        rdchk(`GP_IDX_PORT_B, (~m_dir & m_lat | m_dir) & 255);
        ext_pb_en <= m_dir[7:0];
        apb(1'b1, `GP_IDX_OPT, 8'hff);
        chk(pb_pullup, 0);
        // no port b reads while waiting on the change flag
        m_dir = 8'hf0;
        m_ext = 8'ha0;
        ext_pb <= 8'ha0;
        ext_pb_en <= 8'hf0;
        apb(1'b1, `GP_IDX_PB_DIR, m_dir);
        repeat (3) @(posedge pclk);
        rdchk(`GP_IDX_PORT_B, pbw());
        apb(1'b1, `GP_IDX_INTC, 8'h00);
        rdchk(`GP_IDX_INTC, 0);
        m_ext ^= 8'h20;
        ext_pb <= m_ext[7:0];
        repeat (4) @(posedge pclk);
        rdchk(`GP_IDX_INTC, 1);
        apb(1'b1, `GP_IDX_INTC, 8'h08);
        rdchk(`GP_IDX_INTC, 9);
        chk({change_irq, wake_request}, 1);
        rdchk(`GP_IDX_PORT_B, pbw());
        apb(1'b1, `GP_IDX_INTC, 8'h88);
        rdchk(`GP_IDX_INTC, 8'h88);
        m_ext ^= 8'h01;
        ext_pb <= m_ext[7:0];
        repeat (4) @(posedge pclk);
        rdchk(`GP_IDX_INTC, 8'h88);
        m_ext ^= 8'h80;
        ext_pb <= m_ext[7:0];
        repeat (4) @(posedge pclk);
        chk({change_irq, wake_request}, 3);
        rdchk(`GP_IDX_PORT_B, pbw());
        apb(1'b1, `GP_IDX_INTC, 8'h88);
        m_dir = 8'he0;
        ext_pb_en <= 8'he0;
        apb(1'b1, `GP_IDX_PB_DIR, m_dir);
        m_lat ^= 8'h10;
        apb(1'b1, `GP_IDX_PORT_B, m_lat);
        repeat (4) @(posedge pclk);
        rdchk(`GP_IDX_INTC, 8'h88);
        give_verdict();
    end
endmodule
